// >>> shared/bbox_pkg.sv
// Package with encodings, field positions and constants of the executor.
package bbox_pkg;
  localparam int PC_W      = 21;
  localparam int ADDR_W    = 12;
  localparam int BANK_W    = 4;
  // Opcode and operand field positions in the 16-bit instruction word.
  localparam int OP4_HI    = 15;
  localparam int OP4_LO    = 12;
  localparam int OP8_LO    = 8;
  localparam int BIT_HI    = 11;
  localparam int BIT_LO    = 9;
  localparam int ACC_POS   = 8;
  localparam int REL_SEL   = 11;
  // Opcodes.
  localparam logic [7:0] OPC_BNZ_E  = 8'hE1;
  localparam logic [7:0] OPC_BOV_E  = 8'hE4;
  localparam logic [7:0] OPC_BRANCH_IF_NO_OVERFLOW_E = 8'hE5;
  localparam logic [3:0] OPC_RJMP   = 4'hD;
  localparam logic [3:0] OPC_SETB   = 4'h8;
  localparam logic [3:0] OPC_TOGB   = 4'h7;
  localparam logic [3:0] OPC_TSKC   = 4'hB;
  localparam logic [3:0] OPC_TSKS   = 4'hA;
  // Access bank: addresses below the split map to bank 0, the rest to
  // the top bank.
  localparam logic [7:0] ACC_SPLIT  = 8'h80;
  localparam logic [3:0] ACC_HIBANK = 4'hF;
  localparam logic [3:0] ACC_LOBANK = 4'h0;
  // Quarter phases of an instruction cycle.
  localparam logic [1:0] Q_ONE      = 2'h0;
  localparam logic [1:0] Q_TWO      = 2'h1;
  localparam logic [1:0] Q_FOUR     = 2'h3;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
endpackage

// >>> src/bbox_qgen.sv
// Quarter phase generator of the instruction cycle.
`timescale 1ns/1ns
module bbox_qgen (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  output logic [1:0]      quarter_o,
  output logic            q_four_o
);
  // Counts four quarters, one per system clock.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      quarter_o <= bbox_pkg::Q_ONE;
    end else begin
      quarter_o <= quarter_o + 2'h1;
    end
  end

  // Last quarter strobe.
  assign q_four_o = (quarter_o == bbox_pkg::Q_FOUR);
endmodule

// >>> src/bbox_bitop.sv
// Single-bit modify and test unit for data register values.
`timescale 1ns/1ns
module bbox_bitop (
  input  wire logic [7:0] data_i,
  input  wire logic [2:0] bit_i,
  input  wire logic       toggle_i,
  output logic [7:0]      result_o,
  output logic            bit_o
);
  logic [7:0] mask;

  // Forces the selected bit to one or inverts it.
  always_comb begin
    mask = 8'h01 << bit_i;
    bit_o = data_i[bit_i];
    if (toggle_i) begin
      result_o = data_i ^ mask;
    end else begin
      result_o = data_i | mask;
    end
  end
endmodule

// >>> src/bbox_exec.sv
// Executor for relative branches and single-bit instructions.
// Summary of operation
// - Branch-if-nonzero, 1110 0001 with offset, branches when zero is clear.
// - Branch-if-overflow, 1110 0100 with offset, branches when overflow set.
// - Branch-if-no-overflow, 1110 0101, branches when overflow is clear.
// - A relative branch target is the instruction address plus 2 plus 2n.
// - Untaken branch is one cycle; taken writes PC in quarter four plus a nop.
// - Relative jump 1101 0 with 11-bit offset always branches in two cycles.
// - Set-single-bit 1000 forces the chosen bit of the register to one.
// - Toggle-single-bit 0111 reads in quarter two and writes in quarter four.
// - Test-skip-if-clear 1011 and if-set 1010 skip by discarding the next word.
// - A test is one cycle, two on skip, three if the skipped one is two words.
// - Access flag zero selects the access bank, one uses the bank select reg.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module bbox_exec (
  input  wire logic                     CLK_SYS_I,
  input  wire logic                     RST_I,
  input  wire logic [15:0]              INSTR_I,
  input  wire logic                     NEXT_TWO_WORD_I,
  input  wire logic                     ZERO_I,
  input  wire logic                     OVF_I,
  input  wire logic                     FLAG_WE_I,
  input  wire logic                     ZERO_NEW_I,
  input  wire logic                     OVF_NEW_I,
  input  wire logic [3:0]               BANK_SELECT_REG_I,
  input  wire logic [7:0]               DATA_RD_I,
  output logic [bbox_pkg::PC_W-1:0]     PROGRAM_COUNTER_O,
  output logic [bbox_pkg::ADDR_W-1:0]   DATA_ADDR_O,
  output logic [7:0]                    DATA_WR_O,
  output logic                          DATA_RD_EN_O,
  output logic                          DATA_WE_O,
  output logic                          FLAG_HOLD_O,
  output logic                          NOP_CYCLE_O,
  output logic [1:0]                    QUARTER_O
);
  typedef enum logic [1:0] {BBOX_RUN, BBOX_NOP1, BBOX_NOP2} bbox_state_e;

  bbox_state_e                   state;
  bbox_state_e                   next_state;
  logic [1:0]                    quarter;
  logic                          q_four;
  logic [bbox_pkg::PC_W-1:0]     inst_addr;
  logic [bbox_pkg::PC_W-1:0]     next_pc;
  logic [bbox_pkg::PC_W-1:0]     target;
  logic [bbox_pkg::PC_W-1:0]     offs;
  logic                          is_cond;
  logic                          is_rjmp;
  logic                          is_set;
  logic                          is_tog;
  logic                          is_test;
  logic                          take;
  logic                          zero_now;
  logic                          ovf_now;
  logic [7:0]                    bit_res;
  logic                          bit_val;
  logic                          skip;
  logic [7:0]                    rd_hold;
  logic                          pc_hold;

  // Maps the access flag and file address to a full data address.
  function automatic logic [bbox_pkg::ADDR_W-1:0] data_addr(
    input logic       acc,
    input logic [7:0] f,
    input logic [3:0] bank_select_reg
  );
    logic [3:0] bank;
    bank = bank_select_reg;
    if (!acc) begin
      bank = (f < bbox_pkg::ACC_SPLIT) ? bbox_pkg::ACC_LOBANK
                                       : bbox_pkg::ACC_HIBANK;
    end
    return {bank, f};
  endfunction

  bbox_qgen u_qgen (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RST_I),
    .quarter_o (quarter),
    .q_four_o  (q_four)
  );

  bbox_bitop u_bitop (
    .data_i   (rd_hold),
    .bit_i    (INSTR_I[bbox_pkg::BIT_HI:bbox_pkg::BIT_LO]),
    .toggle_i (is_tog),
    .result_o (bit_res),
    .bit_o    (bit_val)
  );

  assign QUARTER_O = quarter;

  // Instruction decode, only valid in the executing state.
  always_comb begin
    is_cond = 1'b0;
    is_rjmp = 1'b0;
    is_set  = 1'b0;
    is_tog  = 1'b0;
    is_test = 1'b0;
    if (state == BBOX_RUN) begin
      is_cond = (INSTR_I[15:bbox_pkg::OP8_LO] == bbox_pkg::OPC_BNZ_E) ||
                (INSTR_I[15:bbox_pkg::OP8_LO] == bbox_pkg::OPC_BOV_E) ||
                (INSTR_I[15:bbox_pkg::OP8_LO] == bbox_pkg::OPC_BRANCH_IF_NO_OVERFLOW_E);
      is_rjmp = (INSTR_I[bbox_pkg::OP4_HI:bbox_pkg::OP4_LO]
                 == bbox_pkg::OPC_RJMP) && !INSTR_I[bbox_pkg::REL_SEL];
      is_set  = INSTR_I[bbox_pkg::OP4_HI:bbox_pkg::OP4_LO]
                == bbox_pkg::OPC_SETB;
      is_tog  = INSTR_I[bbox_pkg::OP4_HI:bbox_pkg::OP4_LO]
                == bbox_pkg::OPC_TOGB;
      is_test = (INSTR_I[bbox_pkg::OP4_HI:bbox_pkg::OP4_LO]
                 == bbox_pkg::OPC_TSKC) ||
                (INSTR_I[bbox_pkg::OP4_HI:bbox_pkg::OP4_LO]
                 == bbox_pkg::OPC_TSKS);
    end
  end

  // Flags include an update written in the same cycle by the previous op.
  assign zero_now = FLAG_WE_I ? ZERO_NEW_I : ZERO_I;
  assign ovf_now  = FLAG_WE_I ? OVF_NEW_I : OVF_I;

  // Branch condition per opcode.
  always_comb begin
    take = 1'b0;
    case (INSTR_I[15:bbox_pkg::OP8_LO])
      bbox_pkg::OPC_BNZ_E:  take = !zero_now;
      bbox_pkg::OPC_BOV_E:  take = ovf_now;
      bbox_pkg::OPC_BRANCH_IF_NO_OVERFLOW_E: take = !ovf_now;
      default:              take = 1'b0;
    endcase
    take = (take && is_cond) || is_rjmp;
  end

  // Sign-extended doubled offset for the 8-bit and 11-bit forms.
  always_comb begin
    if (is_rjmp) begin
      offs = {{(bbox_pkg::PC_W-12){INSTR_I[10]}}, INSTR_I[10:0], 1'b0};
    end else begin
      offs = {{(bbox_pkg::PC_W-9){INSTR_I[7]}}, INSTR_I[7:0], 1'b0};
    end
    target = inst_addr + bbox_pkg::PC_STEP + offs;
  end

  // Skip decision from the tested bit.
  assign skip = is_test && (bit_val ==
    (INSTR_I[bbox_pkg::OP4_HI:bbox_pkg::OP4_LO] == bbox_pkg::OPC_TSKS));

  // Sequencer: nop cycles after taken branches and skips.
  always_comb begin
    next_state = state;
    case (state)
      BBOX_RUN: begin
        if (take) begin
          next_state = BBOX_NOP1;
        end else if (skip) begin
          next_state = NEXT_TWO_WORD_I ? BBOX_NOP2 : BBOX_NOP1;
        end
      end
      BBOX_NOP2: next_state = BBOX_NOP1;
      BBOX_NOP1: next_state = BBOX_RUN;
      default:   next_state = BBOX_RUN;
    endcase
  end

  // State advances at the end of each instruction cycle.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state <= BBOX_RUN;
    end else if (q_four) begin
      state <= next_state;
    end
  end

  // Remembers that the pending nop follows a taken branch, so the flushed
  // word must not advance the counter past the branch target.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pc_hold <= 1'b0;
    end else if (q_four) begin
      pc_hold <= (state == BBOX_RUN) && take;
    end
  end

  // Program counter: written in quarter four, else steps one word.
  // Skipped words still step it, a flushed branch word does not.
  always_comb begin
    next_pc = PROGRAM_COUNTER_O + bbox_pkg::PC_STEP;
    if (take) begin
      next_pc = target;
    end else if (pc_hold && (state != BBOX_RUN)) begin
      next_pc = PROGRAM_COUNTER_O;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      PROGRAM_COUNTER_O <= bbox_pkg::PC_RST;
      inst_addr         <= bbox_pkg::PC_RST;
    end else if (q_four) begin
      PROGRAM_COUNTER_O <= next_pc;
      inst_addr         <= next_pc;
    end
  end

  // Data address for the bit instructions.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      DATA_ADDR_O <= '0;
    end else if (quarter == bbox_pkg::Q_ONE) begin
      DATA_ADDR_O <= data_addr(INSTR_I[bbox_pkg::ACC_POS], INSTR_I[7:0],
                               BANK_SELECT_REG_I);
    end
  end

  // Read strobe in quarter two; captured value held for the op.
  assign DATA_RD_EN_O = (quarter == bbox_pkg::Q_TWO) &&
                        (is_set || is_tog || is_test);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      rd_hold <= 8'h00;
    end else if (DATA_RD_EN_O) begin
      rd_hold <= DATA_RD_I;
    end
  end

  // Write back of the modified register in quarter four.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      DATA_WE_O <= 1'b0;
      DATA_WR_O <= 8'h00;
    end else begin
      DATA_WE_O <= (quarter == 2'h2) && (is_set || is_tog);
      DATA_WR_O <= bit_res;
    end
  end

  // Status flags are frozen for all instructions handled here.
  assign FLAG_HOLD_O = is_cond || is_rjmp || is_set || is_tog ||
                       is_test || (state != BBOX_RUN);
  assign NOP_CYCLE_O = (state != BBOX_RUN);

  // Checks.
  pc_on_take_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (q_four && take) |=> PROGRAM_COUNTER_O == $past(target))
    else $error("taken branch did not load target");
  nop_after_take_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (q_four && take) |=> NOP_CYCLE_O [*4])
    else $error("no nop cycle after taken branch");
  untaken_step_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (q_four && is_cond && !take) |=>
      PROGRAM_COUNTER_O ==
        $past(PROGRAM_COUNTER_O) + bbox_pkg::PC_STEP)
    else $error("untaken branch did not step");
  ovf_cond_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (is_cond && INSTR_I[15:8] == bbox_pkg::OPC_BOV_E) |->
      take == ovf_now)
    else $error("overflow branch condition wrong");
  novf_cond_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (is_cond && INSTR_I[15:8] == bbox_pkg::OPC_BRANCH_IF_NO_OVERFLOW_E) |->
      take == !ovf_now)
    else $error("no-overflow branch condition wrong");
  rjmp_always_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    is_rjmp |-> take)
    else $error("relative jump not taken");
  skip_two_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (q_four && skip && NEXT_TWO_WORD_I && !take) |=> NOP_CYCLE_O [*8])
    else $error("two-word skip too short");
  write_q4_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    DATA_WE_O |-> quarter == bbox_pkg::Q_FOUR)
    else $error("write back outside quarter four");
  flag_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (is_set || is_tog || is_test) |-> FLAG_HOLD_O)
    else $error("flags not held");
  // The flushed word after a taken branch leaves the target in place.
  pc_flush_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (q_four && pc_hold && state == BBOX_NOP1) |=>
      PROGRAM_COUNTER_O == $past(PROGRAM_COUNTER_O))
    else $error("counter moved during branch flush");
  // The data read strobe belongs to quarter two only.
  read_q2_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    DATA_RD_EN_O |-> quarter == bbox_pkg::Q_TWO)
    else $error("read strobe outside quarter two");
  // Nop cycles never let the status flags move.
  nop_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    NOP_CYCLE_O |-> FLAG_HOLD_O)
    else $error("flags not held in nop cycle");
  // With the access flag clear the bank is one of the two access halves.
  access_bank_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (quarter == bbox_pkg::Q_TWO && (is_set || is_tog || is_test) &&
     !INSTR_I[bbox_pkg::ACC_POS]) |->
      (DATA_ADDR_O[11:8] == bbox_pkg::ACC_LOBANK ||
       DATA_ADDR_O[11:8] == bbox_pkg::ACC_HIBANK))
    else $error("access bank not selected");

  taken_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    q_four && take && is_cond);
  skip_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    q_four && skip);
  toggle_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    DATA_WE_O && is_tog);
  skip_long_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    q_four && skip && NEXT_TWO_WORD_I);
  jump_c: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    q_four && is_rjmp);
endmodule

// >>> dv/bbox_exec_tb.sv
// Self-checking bench of the branch and single-bit executor.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, (g), (e)); end end
module bbox_exec_tb;
  logic                       clk;
  logic                       rst;
  logic [15:0]                instr;
  logic                       two_word;
  logic                       zero, ovf, flag_we, zero_new, ovf_new;
  logic [3:0]                 bank;
  logic [7:0]                 rd;
  logic [bbox_pkg::PC_W-1:0]  pc_o, pc;
  logic [11:0]                addr_o;
  logic [7:0]                 wr_o;
  logic                       rd_en, we, hold, no_operation;
  logic [1:0]                 quarter;
  int                         tests_run, error_cnt, pend;

  bbox_exec bbox_exec_inst (
    .CLK_SYS_I         (clk),
    .RST_I             (rst),
    .INSTR_I           (instr),
    .NEXT_TWO_WORD_I   (two_word),
    .ZERO_I            (zero),
    .OVF_I             (ovf),
    .FLAG_WE_I         (flag_we),
    .ZERO_NEW_I        (zero_new),
    .OVF_NEW_I         (ovf_new),
    .BANK_SELECT_REG_I (bank),
    .DATA_RD_I         (rd),
    .PROGRAM_COUNTER_O (pc_o),
    .DATA_ADDR_O       (addr_o),
    .DATA_WR_O         (wr_o),
    .DATA_RD_EN_O      (rd_en),
    .DATA_WE_O         (we),
    .FLAG_HOLD_O       (hold),
    .NOP_CYCLE_O       (no_operation),
    .QUARTER_O         (quarter)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Runs one instruction cycle; flags are {we, zero_new, ovf_new, z, v}.
  task automatic exec(input logic [15:0] ins, input logic [4:0] fl,
                      input logic [3:0] bs, input logic [7:0] rdv,
                      input logic tw);
    logic                      z, v, take, skip, bitop, wr_en, known;
    logic [7:0]                mask, wr_exp;
    logic [11:0]               addr;
    logic [bbox_pkg::PC_W-1:0] n21;
    @(posedge clk);
    instr <= ins;
    {flag_we, zero_new, ovf_new, zero, ovf} <= fl;
    bank <= bs;
    rd <= rdv;
    two_word <= tw;
    // Pending no-operation cycles ignore the word just presented.
    repeat (pend) begin
      #1 `CHK(no_operation, 1'b1)
      repeat (4) @(posedge clk);
    end
    #1;
    `CHK(pc_o, pc)
    `CHK(no_operation, 1'b0)
    `CHK(quarter, 2'h0)
    z = fl[4] ? fl[3] : fl[1];
    v = fl[4] ? fl[2] : fl[0];
    mask = 8'h01 << ins[11:9];
    bitop = ins[15:12] inside {4'h8, 4'h7, 4'hB, 4'hA};
    wr_en = ins[15:12] inside {4'h8, 4'h7};
    wr_exp = (ins[15:12] == 4'h8) ? (rdv | mask) : (rdv ^ mask);
    addr = ins[8] ? {bs, ins[7:0]} : {ins[7] ? 4'hF : 4'h0, ins[7:0]};
    n21 = (ins[15:12] == 4'hD) ? {{10{ins[10]}}, ins[10:0]}
                               : {{13{ins[7]}}, ins[7:0]};
    take = (ins[15:8] == 8'hE1 && !z) || (ins[15:8] == 8'hE4 && v) ||
           (ins[15:8] == 8'hE5 && !v) || ins[15:11] == 5'h1A;
    skip = (ins[15:12] == 4'hB && (rdv & mask) == 8'h00) ||
           (ins[15:12] == 4'hA && (rdv & mask) != 8'h00);
    known = bitop || ins[15:8] inside {8'hE1, 8'hE4, 8'hE5} ||
            ins[15:11] == 5'h1A;
    @(posedge clk);
    #1;
    `CHK(rd_en, bitop)
    if (bitop) `CHK(addr_o, addr)
    repeat (2) @(posedge clk);
    #1;
    `CHK(we, wr_en)
    if (wr_en) `CHK(wr_o, wr_exp)
    if (known) `CHK(hold, 1'b1)
    pc = take ? pc + 21'h000002 + (n21 << 1) : pc + 21'h000002;
    if (skip) pc = pc + (tw ? 21'h000004 : 21'h000002);
    pend = take ? 1 : (skip ? (tw ? 2 : 1) : 0);
  endtask

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short; the sequence needs about 125 clocks.
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end

  // Main sequence of instruction cycles.
  initial begin
    rst = 1'b1;
    instr = 16'h0000;
    {two_word, zero, ovf, flag_we, zero_new, ovf_new} = 6'h00;
    bank = 4'h0;
    rd = 8'h00;
    tests_run = 0;
    error_cnt = 0;
    pend = 0;
    pc = 21'h000002;
    repeat (8) @(posedge clk);
    `CHK(pc_o, 21'h000000)
    rst <= 1'b0;
    // The idle word after reset steps the counter once; align to quarter 3.
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if (quarter === 2'h3) break;
    end
    exec(16'hE105, 5'h00, 4'h0, 8'h00, 1'b0);
    exec(16'hE1FF, 5'h02, 4'h0, 8'h00, 1'b0);
    exec(16'hE480, 5'h01, 4'h0, 8'h00, 1'b0);
    exec(16'hE47F, 5'h00, 4'h0, 8'h00, 1'b0);
    exec(16'hE57F, 5'h00, 4'h0, 8'h00, 1'b0);
    exec(16'hE580, 5'h01, 4'h0, 8'h00, 1'b0);
    exec(16'hD3FF, 5'h03, 4'h0, 8'h00, 1'b0);
    exec(16'hD400, 5'h00, 4'h0, 8'h00, 1'b0);
    exec(16'h8E85, 5'h00, 4'h3, 8'h0A, 1'b0);
    exec(16'h7912, 5'h00, 4'h5, 8'h75, 1'b0);
    exec(16'hB210, 5'h00, 4'h0, 8'h00, 1'b0);
    exec(16'hB210, 5'h00, 4'h0, 8'h02, 1'b0);
    exec(16'hA110, 5'h00, 4'h2, 8'h01, 1'b1);
    exec(16'hA110, 5'h00, 4'h2, 8'hFE, 1'b1);
    exec(16'hE105, 5'h12, 4'h0, 8'h00, 1'b0);
    exec(16'hE105, 5'h18, 4'h0, 8'h00, 1'b0);
    exec(16'hE402, 5'h14, 4'h0, 8'h00, 1'b0);
    exec(16'h0000, 5'h00, 4'h0, 8'h00, 1'b0);
    print_verdict();
  end
endmodule
